// >>> design/pflb_core.sv
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module pflb_core
  import pflb_pkg::*;
#(
  parameter int NUM_FAULTS = 8,
  parameter int NUM_CMPS = 5
) (
  input wire logic core_clk_in, // pwm clock
  input wire logic rst_in, // synchronous, active high
  input wire logic [2:0] avs_address_in, // word address
  input wire logic avs_read_in, // read strobe
  input wire logic avs_write_in, // write strobe
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic write_lock_config_in, // lock strap
  input wire logic pwm_module_enable_in, // module enabled
  input wire logic [NUM_FAULTS-1:0] fault_pins_in, // fault pins 1..8
  input wire logic fault32_in, // fault 32 pin
  input wire logic [NUM_CMPS-1:0] cmp_in, // comparators, same clock
  input wire logic [15:0] time_base_in, // local time base
  input wire logic period_start_in, // period boundary pulse
  input wire logic high_gen_in, // generator high output
  input wire logic low_gen_in, // generator low output
  input wire logic [2:0] gen_high_in, // generators 1..3 high, same clock
  input wire logic chop_clk_in, // chop clock generator, same clock
  output logic high_side_output_out, // conditioned high output
  output logic low_side_output_out, // conditioned low output
  output logic adc_trigger_out, // adc trigger pulse
  output logic fault_active_out, // fault override
  output logic limit_active_out // limit override
);
  // ==========================================================
  // registers
  logic [15:0] adc_trigger_compare;
  logic [15:0] fault_limit_control;
  logic [15:0] edge_blanking_control;
  logic [15:0] edge_blanking_delay;
  logic [15:0] auxiliary_blank_chop_control;
  logic [3:0] out_values; // {fault_h, fault_l, limit_h, limit_l}
  pflb_unlock_t unlock_state;
  logic wr_lo, rd_pending;
  logic leb_busy, blank_active; // status bits, also read back
  logic [15:0] wdata;
  assign wdata = avs_writedata_in[15:0];
  // upper lanes hold only zero bits, so only lanes 0/1 matter
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
    logic [15:0] be;
    be = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    merge = ((old & ~be) | (wdata & be)) & msk;
  endfunction : merge

  function automatic logic pick_src(input logic [4:0] code, input logic [NUM_FAULTS-1:0] f,
                                    input logic [NUM_CMPS-1:0] c, input logic f32);
    pick_src = 1'b0;
    if (code < SRC_CMP_FIRST) pick_src = f[code[2:0]];
    else if (code <= SRC_CMP_LAST) pick_src = c[3'(code - SRC_CMP_FIRST)];
    else if (code == SRC_FAULT32) pick_src = f32;
  endfunction : pick_src

  function automatic logic pick_gen(input logic [3:0] code, input logic dflt);
    pick_gen = 1'b0;
    if (code == 4'h0) pick_gen = dflt;
    else if (code <= 4'h3) pick_gen = gen_high_in[2'(code - 4'h1)];
  endfunction : pick_gen

  // ==========================================================
  // avalon slave: reads stall one cycle, writes never
  // readdata is registered, so the stall lets it stand at the accept edge
  assign avs_waitrequest_out = avs_read_in && !rd_pending;
  assign wr_lo = avs_write_in && avs_byteenable_in[0];
  logic fl_write_ok;
  assign fl_write_ok = !write_lock_config_in || unlock_state == PFLB_UNLOCK_OPEN;
  logic latch_clear;
  assign latch_clear = avs_write_in && avs_address_in == ADDR_STATUS && wr_lo && wdata[0];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      unlock_state <= PFLB_UNLOCK_IDLE;
    end else if (avs_write_in) begin
      case (unlock_state)
        PFLB_UNLOCK_IDLE:
          if (avs_address_in == ADDR_UNLOCK && wdata == UNLOCK_KEY1) begin
            unlock_state <= PFLB_UNLOCK_KEY1;
          end
        PFLB_UNLOCK_KEY1:
          if (avs_address_in == ADDR_UNLOCK && wdata == UNLOCK_KEY2) begin
            unlock_state <= PFLB_UNLOCK_OPEN;
          end else begin
            unlock_state <= PFLB_UNLOCK_IDLE;
          end
        PFLB_UNLOCK_OPEN:
          // any one write closes the window again
          unlock_state <= PFLB_UNLOCK_IDLE;
        default: unlock_state <= PFLB_UNLOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      adc_trigger_compare <= ZERO16;
      fault_limit_control <= FAULT_LIMIT_RST;
      edge_blanking_control <= ZERO16;
      edge_blanking_delay <= ZERO16;
      auxiliary_blank_chop_control <= ZERO16;
      out_values <= 4'h0;
    end else if (avs_write_in) begin
      case (avs_address_in)
        ADDR_TRIG_CMP: adc_trigger_compare <= merge(adc_trigger_compare, 16'hffff);
        ADDR_FAULT_LIMIT:
          if (fl_write_ok) begin
            fault_limit_control <= merge(fault_limit_control, FAULT_LIMIT_MASK);
          end
        ADDR_BLANK_CTRL:
          edge_blanking_control <= merge(edge_blanking_control, BLANK_CTRL_MASK);
        ADDR_BLANK_DELAY:
          edge_blanking_delay <= merge(edge_blanking_delay, BLANK_DELAY_MASK);
        ADDR_AUX_CTRL:
          auxiliary_blank_chop_control <=
            merge(auxiliary_blank_chop_control, AUX_CTRL_MASK);
        ADDR_OUT_VALUES: if (wr_lo) out_values <= wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= avs_read_in && !rd_pending; // one stall cycle per read
      case (avs_address_in)
        ADDR_TRIG_CMP: avs_readdata_out <= {16'h0000, adc_trigger_compare};
        ADDR_FAULT_LIMIT: avs_readdata_out <= {16'h0000, fault_limit_control};
        ADDR_BLANK_CTRL: avs_readdata_out <= {16'h0000, edge_blanking_control};
        ADDR_BLANK_DELAY: avs_readdata_out <= {16'h0000, edge_blanking_delay};
        ADDR_AUX_CTRL: avs_readdata_out <= {16'h0000, auxiliary_blank_chop_control};
        ADDR_OUT_VALUES: avs_readdata_out <= {28'h0000000, out_values};
        ADDR_STATUS: avs_readdata_out <= {28'h0000000, blank_active, leb_busy,
                                          limit_active_out, fault_active_out};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // field extraction
  logic [4:0] limit_source_select, fault_source_select;
  logic limit_source_polarity, limit_function_enable, fault_source_polarity;
  logic [1:0] fault_response_mode;
  assign limit_source_select = fault_limit_control[LIM_SRC_LSB +: 5];
  assign limit_source_polarity = fault_limit_control[LIM_POL_BIT];
  assign limit_function_enable = fault_limit_control[LIM_EN_BIT];
  assign fault_source_select = fault_limit_control[FLT_SRC_LSB +: 5];
  assign fault_source_polarity = fault_limit_control[FLT_POL_BIT];
  assign fault_response_mode = fault_limit_control[FLT_MODE_LSB +: 2];

  // ==========================================================
  // pin synchronisers; first stage feeds the second only
  logic [NUM_FAULTS:0] pin_meta, pin_sync;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {fault32_in, fault_pins_in};
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // source selection and polarity
  logic fault_raw, limit_raw;
  // polarity changes with the module running may glitch the override
  assign limit_raw = pick_src(limit_source_select, pin_sync[NUM_FAULTS-1:0], cmp_in,
                              pin_sync[NUM_FAULTS]) ^ limit_source_polarity;
  assign fault_raw = pick_src(fault_source_select, pin_sync[NUM_FAULTS-1:0], cmp_in,
                              pin_sync[NUM_FAULTS]) ^ fault_source_polarity;

  // ==========================================================
  // leading-edge and state blanking
  logic high_q, low_q, leb_trig;
  logic [11:0] leb_count;
  logic [11:0] edge_blank_duration;
  assign edge_blank_duration = edge_blanking_delay[11:0];
  logic high_rise_blank_trigger, high_fall_blank_trigger;
  logic low_rise_blank_trigger, low_fall_blank_trigger;
  logic fault_edge_blank_enable, limit_edge_blank_enable;
  logic blank_on_signal_high, blank_on_signal_low;
  logic [3:0] state_blank_source_select, chop_source_select;
  logic high_out_chop_enable, low_out_chop_enable;
  assign {high_rise_blank_trigger, high_fall_blank_trigger, low_rise_blank_trigger,
          low_fall_blank_trigger} = edge_blanking_control[LEB_TRIG_LSB +: 4];
  assign fault_edge_blank_enable = edge_blanking_control[FLT_LEB_BIT];
  assign limit_edge_blank_enable = edge_blanking_control[LIM_LEB_BIT];
  assign blank_on_signal_high = edge_blanking_control[BLANK_HI_BIT];
  assign blank_on_signal_low = edge_blanking_control[BLANK_LO_BIT];
  assign state_blank_source_select = auxiliary_blank_chop_control[BLANK_SEL_LSB +: 4];
  assign chop_source_select = auxiliary_blank_chop_control[CHOP_SEL_LSB +: 4];
  assign high_out_chop_enable = auxiliary_blank_chop_control[CHOP_H_BIT];
  assign low_out_chop_enable = auxiliary_blank_chop_control[CHOP_L_BIT];
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      high_q <= high_gen_in;
      low_q <= low_gen_in;
    end
  end
  assign leb_trig = (high_rise_blank_trigger && high_gen_in && !high_q)
                 || (high_fall_blank_trigger && !high_gen_in && high_q)
                 || (low_rise_blank_trigger && low_gen_in && !low_q)
                 || (low_fall_blank_trigger && !low_gen_in && low_q);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      leb_count <= 12'h000;
    end else if (leb_trig) begin
      leb_count <= edge_blank_duration;
    end else if (leb_count != 12'h000) begin
      leb_count <= leb_count - 12'h001;
    end
  end
  assign leb_busy = leb_trig || leb_count != 12'h000;

  logic blank_sig;
  assign blank_sig = pick_gen(state_blank_source_select, 1'b0);
  logic [3:0] state_en;
  assign state_en = edge_blanking_control[STATE_BLANK_LSB +: 4];
  assign blank_active = (state_en[3] && high_gen_in) || (state_en[2] && !high_gen_in)
                     || (state_en[1] && low_gen_in) || (state_en[0] && !low_gen_in)
                     || (state_blank_source_select != 4'h0
                         && ((blank_on_signal_high && blank_sig)
                             || (blank_on_signal_low && !blank_sig)));

  logic fault_in, limit_in;
  assign fault_in = fault_raw && !blank_active
                 && !(fault_edge_blank_enable && leb_busy);
  assign limit_in = limit_raw && !blank_active
                 && !(limit_edge_blank_enable && leb_busy);

  // ==========================================================
  // fault and limit override state
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      fault_active_out <= 1'b0;
    end else if (fault_response_mode == FMODE_OFF || fault_response_mode == 2'h2) begin
      fault_active_out <= 1'b0;
    end else if (fault_in) begin
      fault_active_out <= 1'b1; // set wins over clear
    end else if (fault_response_mode == FMODE_LATCH && latch_clear) begin
      fault_active_out <= 1'b0;
    end else if (fault_response_mode == FMODE_CYCLE && period_start_in) begin
      fault_active_out <= 1'b0;
    end
  end

  // limit is cycle by cycle: holds until the next period once source drops
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      limit_active_out <= 1'b0;
    end else if (!limit_function_enable) begin
      limit_active_out <= 1'b0;
    end else if (limit_in) begin
      limit_active_out <= 1'b1;
    end else if (period_start_in) begin
      limit_active_out <= 1'b0;
    end
  end

  // ==========================================================
  // output conditioning and adc trigger
  logic chop_sig;
  assign chop_sig = pick_gen(chop_source_select, chop_clk_in);
  logic next_high, next_low;
  always_comb begin
    next_high = high_gen_in;
    next_low = low_gen_in;
    if (high_out_chop_enable) next_high = high_gen_in && chop_sig;
    if (low_out_chop_enable) next_low = low_gen_in && chop_sig;
    if (limit_active_out) begin
      next_high = out_values[1];
      next_low = out_values[0];
    end
    if (fault_active_out) begin
      next_high = out_values[3]; // fault outranks limit
      next_low = out_values[2];
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      high_side_output_out <= 1'b0;
      low_side_output_out <= 1'b0;
      adc_trigger_out <= 1'b0;
    end else begin
      high_side_output_out <= next_high;
      low_side_output_out <= next_low;
      adc_trigger_out <= pwm_module_enable_in && time_base_in == adc_trigger_compare;
    end
  end

  // ==========================================================
  // assertions
  property p_fault_src_reset;
    @(posedge core_clk_in) $fell(rst_in) |->
      fault_source_select == SRC_FAULT32 && !limit_function_enable;
  endproperty
  a_fault_src_reset: assert property (p_fault_src_reset) else $error("bad reset");
  property p_reserved_zero;
    @(posedge core_clk_in) disable iff (rst_in) fault_limit_control[15] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
  property p_lock;
    @(posedge core_clk_in) disable iff (rst_in)
      (avs_write_in && avs_address_in == ADDR_FAULT_LIMIT && write_lock_config_in
       && unlock_state != PFLB_UNLOCK_OPEN) |=> $stable(fault_limit_control);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  property p_fault_out;
    @(posedge core_clk_in) disable iff (rst_in)
      fault_active_out |=> high_side_output_out == $past(out_values[3])
                           && low_side_output_out == $past(out_values[2]);
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("fault values not driven");
  property p_limit_out;
    @(posedge core_clk_in) disable iff (rst_in)
      (limit_active_out && !fault_active_out) |=> high_side_output_out == $past(out_values[1]);
  endproperty
  a_limit_out: assert property (p_limit_out) else $error("limit values not driven");
  property p_limit_off;
    @(posedge core_clk_in) disable iff (rst_in)
      !limit_function_enable |=> !limit_active_out;
  endproperty
  a_limit_off: assert property (p_limit_off) else $error("limit active while off");
  property p_mode_off;
    @(posedge core_clk_in) disable iff (rst_in)
      fault_response_mode == FMODE_OFF |=> !fault_active_out;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("fault active while disabled");
  property p_latch_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      (fault_active_out && fault_response_mode == FMODE_LATCH && !latch_clear) |=>
        fault_active_out || $past(fault_response_mode) != FMODE_LATCH;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault dropped");
  property p_leb_mask;
    @(posedge core_clk_in) disable iff (rst_in)
      (edge_blanking_control[11] && leb_busy) |-> !fault_in;
  endproperty
  a_leb_mask: assert property (p_leb_mask) else $error("fault seen during blanking");
  property p_leb_load;
    @(posedge core_clk_in) disable iff (rst_in)
      leb_trig |=> leb_count == $past(edge_blank_duration);
  endproperty
  a_leb_load: assert property (p_leb_load) else $error("blank counter not loaded");
  property p_trig;
    @(posedge core_clk_in) disable iff (rst_in)
      (pwm_module_enable_in && time_base_in == adc_trigger_compare) |=> adc_trigger_out;
  endproperty
  a_trig: assert property (p_trig) else $error("adc trigger missed");
  // read data must already stand at the edge where the stall ends
  property p_read_delay;
    @(posedge core_clk_in) disable iff (rst_in)
      (avs_read_in && !avs_waitrequest_out && avs_address_in == ADDR_BLANK_DELAY)
        |-> avs_readdata_out == {20'h00000, edge_blank_duration};
  endproperty
  a_read_delay: assert property (p_read_delay) else $error("delay readback wrong");
  c_fault: cover property (@(posedge core_clk_in) $rose(fault_active_out));
  c_limit: cover property (@(posedge core_clk_in) $rose(limit_active_out));
  c_leb: cover property (@(posedge core_clk_in) leb_trig ##1 leb_busy [*3]);
  c_unlock: cover property (@(posedge core_clk_in) unlock_state == PFLB_UNLOCK_OPEN);
endmodule : pflb_core

// >>> design/pflb_pkg.sv
package pflb_pkg;
  // ==========================================================
  // register word addresses (avalon word offsets)
  localparam logic [2:0] ADDR_TRIG_CMP = 3'h0;
  localparam logic [2:0] ADDR_FAULT_LIMIT = 3'h1;
  localparam logic [2:0] ADDR_BLANK_CTRL = 3'h2;
  localparam logic [2:0] ADDR_BLANK_DELAY = 3'h3;
  localparam logic [2:0] ADDR_AUX_CTRL = 3'h4;
  localparam logic [2:0] ADDR_OUT_VALUES = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_UNLOCK = 3'h7;
  // ==========================================================
  // writable masks and reset values
  localparam logic [15:0] FAULT_LIMIT_MASK = 16'h7fff;
  localparam logic [15:0] FAULT_LIMIT_RST = 16'h00f8;
  localparam logic [15:0] BLANK_CTRL_MASK = 16'hfc3f;
  localparam logic [15:0] BLANK_DELAY_MASK = 16'h0fff;
  localparam logic [15:0] AUX_CTRL_MASK = 16'h0f3f;
  localparam logic [15:0] OUT_VALUES_MASK = 16'h000f;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_KEY2 = 16'h0055;
  // ==========================================================
  // field positions inside fault_limit_control
  localparam int LIM_SRC_LSB = 10;
  localparam int LIM_POL_BIT = 9;
  localparam int LIM_EN_BIT = 8;
  localparam int FLT_SRC_LSB = 3;
  localparam int FLT_POL_BIT = 2;
  localparam int FLT_MODE_LSB = 0;
  // ==========================================================
  // field positions inside edge_blanking_control
  localparam int LEB_TRIG_LSB = 12;
  localparam int FLT_LEB_BIT = 11;
  localparam int LIM_LEB_BIT = 10;
  localparam int BLANK_HI_BIT = 5;
  localparam int BLANK_LO_BIT = 4;
  localparam int STATE_BLANK_LSB = 0;
  // field positions inside auxiliary_blank_chop_control
  localparam int BLANK_SEL_LSB = 8;
  localparam int CHOP_SEL_LSB = 2;
  localparam int CHOP_H_BIT = 1;
  localparam int CHOP_L_BIT = 0;
  // fault modes
  localparam logic [1:0] FMODE_LATCH = 2'h0;
  localparam logic [1:0] FMODE_CYCLE = 2'h1;
  localparam logic [1:0] FMODE_OFF = 2'h3;
  // source codes
  localparam logic [4:0] SRC_CMP_FIRST = 5'h08;
  localparam logic [4:0] SRC_CMP_LAST = 5'h0c;
  localparam logic [4:0] SRC_FAULT32 = 5'h1f;
  typedef enum logic [1:0] {
    PFLB_UNLOCK_IDLE = 2'b00,
    PFLB_UNLOCK_KEY1 = 2'b01,
    PFLB_UNLOCK_OPEN = 2'b10
  } pflb_unlock_t;
endpackage : pflb_pkg

// >>> sim/pflb_far.sv
`timescale 1ns/100ps
// ==========================================================
// far side: fault pins, comparators, time base, chop clock
module pflb_far #(
  parameter int PERIOD = 64
) (
  input wire logic core_clk_in, // pwm clock
  input wire logic rst_in, // sync reset
  input wire logic [13:0] cmd_in, // pins, comparators, fault 32
  output logic [7:0] pins_out, // fault pins
  output logic f32_out, // fault 32
  output logic [4:0] cmp_out, // comparators
  output logic [15:0] tb_out, // local time base
  output logic per_out, // period boundary
  output logic chop_out // chop clock
);
  // pins change one edge after the command, like a slow board trace
  always_ff @(posedge core_clk_in) begin
    {f32_out, cmp_out, pins_out} <= cmd_in;
    if (rst_in || tb_out == 16'(PERIOD - 1)) begin
      tb_out <= 16'h0000;
    end else begin
      tb_out <= tb_out + 16'h0001;
    end
  end
  assign per_out = (tb_out == 16'h0000);
  assign chop_out = tb_out[2];
endmodule : pflb_far

// >>> sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pflb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic lock = 1'b0;
  logic pen = 1'b0;
  logic [13:0] cmd = 14'h0;
  logic hg = 1'b0;
  logic lg = 1'b0;
  logic [2:0] gh = 3'h0;
  logic [7:0] pins;
  logic f32, per, chop, ho, lo, trig, fa, la, cb;
  logic [4:0] cmp;
  logic [4:0] code;
  logic [15:0] tbase, rv;
  logic [15:0] msk [4] = '{FAULT_LIMIT_MASK, BLANK_CTRL_MASK, BLANK_DELAY_MASK, AUX_CTRL_MASK};
  logic [15:0] bctl [9] = '{16'h8800, 16'h4800, 16'h8400, 16'h0008, 16'h0020,
                            16'h2800, 16'h0002, 16'h0010, 16'h0005};
  logic bexp [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int err_count = 0;
  int comparisons = 0;
  int n;
  always #12.5 clk = ~clk;
  pflb_far pflb_far_i (.core_clk_in(clk), .rst_in(rst), .cmd_in(cmd), .pins_out(pins),
    .f32_out(f32), .cmp_out(cmp), .tb_out(tbase), .per_out(per), .chop_out(chop));
  pflb_core pflb_core_i (.core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h3),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .write_lock_config_in(lock),
    .pwm_module_enable_in(pen), .fault_pins_in(pins), .fault32_in(f32), .cmp_in(cmp),
    .time_base_in(tbase), .period_start_in(per), .high_gen_in(hg), .low_gen_in(lg),
    .gen_high_in(gh), .chop_clk_in(chop), .high_side_output_out(ho),
    .low_side_output_out(lo), .adc_trigger_out(trig), .fault_active_out(fa),
    .limit_active_out(la));
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    adr <= a;
    wd <= {16'h0000, d};
    wr <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    adr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat[15:0];
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk16
  task automatic chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk1
  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(ADDR_FAULT_LIMIT, rv);
    chk16(rv, FAULT_LIMIT_RST);
    for (int i = 1; i < 5; i++) begin
      rd_reg(3'(i), rv);
      if (i > 1) chk16(rv, ZERO16);
      wr_reg(3'(i), 16'hffff);
      rd_reg(3'(i), rv);
      chk16(rv, msk[i-1]);
      wr_reg(3'(i), (i == 1) ? 16'h0003 : ZERO16);
    end
    wr_reg(ADDR_FAULT_LIMIT, ZERO16);
    repeat (70) @(posedge clk);
    lock <= 1'b1;
    wr_reg(ADDR_FAULT_LIMIT, 16'h0003);
    rd_reg(ADDR_FAULT_LIMIT, rv);
    chk16(rv, ZERO16);
    wr_reg(ADDR_UNLOCK, UNLOCK_KEY1);
    wr_reg(ADDR_UNLOCK, UNLOCK_KEY2);
    wr_reg(ADDR_FAULT_LIMIT, 16'h0003);
    wr_reg(ADDR_FAULT_LIMIT, ZERO16);
    rd_reg(ADDR_FAULT_LIMIT, rv);
    chk16(rv, 16'h0003);
    lock <= 1'b0;
    wr_reg(ADDR_OUT_VALUES, 16'h0009);
    lg <= 1'b1;
    cmd[0] <= 1'b1;
    repeat (8) @(posedge clk);
    chk1(fa, 1'b0);
    wr_reg(ADDR_FAULT_LIMIT, ZERO16);
    repeat (8) @(posedge clk);
    chk1(fa, 1'b1);
    chk1(ho, 1'b1);
    chk1(lo, 1'b0);
    cmd[0] <= 1'b0;
    repeat (70) @(posedge clk);
    chk1(fa, 1'b1);
    wr_reg(ADDR_STATUS, 16'h0001);
    repeat (3) @(posedge clk);
    chk1(fa, 1'b0);
    for (int i = 0; i < 14; i++) begin
      code = (i == 13) ? SRC_FAULT32 : 5'(i);
      for (int k = 0; k < 2; k++) begin
        wr_reg(ADDR_FAULT_LIMIT, (k == 0) ? {8'h00, code, 3'b001} : {1'b0, code, 10'h103});
        cmd[i] <= 1'b1;
        repeat (8) @(posedge clk);
        chk1((k == 0) ? fa : la, 1'b1);
        cmd[i] <= 1'b0;
        repeat (70) @(posedge clk);
        chk1((k == 0) ? fa : la, 1'b0);
      end
    end
    hg <= 1'b1;
    lg <= 1'b0;
    wr_reg(ADDR_FAULT_LIMIT, 16'h2303);
    repeat (8) @(posedge clk);
    chk1(la, 1'b1);
    chk1(ho, 1'b0);
    chk1(lo, 1'b1);
    wr_reg(ADDR_FAULT_LIMIT, 16'h2203);
    repeat (70) @(posedge clk);
    chk1(la, 1'b0);
    wr_reg(ADDR_FAULT_LIMIT, 16'h0001);
    wr_reg(ADDR_BLANK_DELAY, 16'h0014);
    wr_reg(ADDR_AUX_CTRL, 16'h0100);
    gh <= 3'h1;
    for (int k = 0; k < 9; k++) begin
      wr_reg(ADDR_BLANK_CTRL, bctl[k]);
      hg <= 1'b0;
      lg <= 1'b0;
      repeat (30) @(posedge clk);
      hg <= 1'b1;
      lg <= 1'b1;
      cmd[0] <= 1'b1;
      repeat (10) @(posedge clk);
      chk1(fa, bexp[k]);
      repeat (30) @(posedge clk);
      if (k == 0) chk1(fa, 1'b1);
      cmd[0] <= 1'b0;
      repeat (70) @(posedge clk);
    end
    wr_reg(ADDR_BLANK_CTRL, ZERO16);
    wr_reg(ADDR_FAULT_LIMIT, 16'h0003);
    wr_reg(ADDR_AUX_CTRL, 16'h0006);
    lg <= 1'b1;
    gh <= 3'h0;
    repeat (4) @(posedge clk);
    chk1(ho, 1'b0);
    chk1(lo, 1'b1);
    gh <= 3'h1;
    repeat (4) @(posedge clk);
    chk1(ho, 1'b1);
    wr_reg(ADDR_AUX_CTRL, 16'h0002);
    repeat (8) begin
      cb = chop;
      @(posedge clk);
      chk1(ho, cb);
    end
    wr_reg(ADDR_TRIG_CMP, 16'h0020);
    rd_reg(ADDR_TRIG_CMP, rv);
    chk16(rv, 16'h0020);
    for (int k = 0; k < 2; k++) begin
      pen <= (k == 0);
      n = 0;
      repeat (64) begin
        @(posedge clk);
        if (trig === 1'b1) n++;
      end
      chk16(16'(n), (k == 0) ? 16'h0001 : 16'h0000);
    end
    end_of_test();
  end
endmodule : tb_top
